// file: adfe_map.vh
// register map, field positions, reset values and timing counts for the acquisition front end
// assumes a 20 MHz clk; included by the design file by its bare name
`ifndef ADFE_MAP_VH
`define ADFE_MAP_VH
// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define ADFE_A_CTRL      8'h00
`define ADFE_A_DECIM     8'h04
`define ADFE_A_TRIG      8'h08
`define ADFE_A_LO_STEP   8'h0C
`define ADFE_A_DITHER    8'h10
`define ADFE_A_STATUS    8'h14
`define ADFE_A_FIFO      8'h18
`define ADFE_A_SRCMEM    8'h1C
`define ADFE_A_SRCADDR   8'h20
`define ADFE_A_TACHADDR  8'h24
`define ADFE_A_TACHDATA  8'h28
`define ADFE_A_RECLEN    8'h2C
// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define ADFE_C_SRCSEL    0
`define ADFE_C_MIXEN     1
`define ADFE_C_ARM       2
`define ADFE_C_SRCEN     3
`define ADFE_C_TRIGSRC   4
`define ADFE_C_STYPE_LO  5
`define ADFE_C_STYPE_HI  6
`define ADFE_C_PRE       7
// source types
`define ADFE_ST_RANDOM   2'h0
`define ADFE_ST_PINK     2'h1
`define ADFE_ST_SINE     2'h2
`define ADFE_ST_ARB      2'h3
// ---------------------------------------------------------------
// reset values and sizes
// ---------------------------------------------------------------
`define ADFE_CTRL_RST    8'h00
`define ADFE_DECIM_RST   4'h0
`define ADFE_LFSR_SEED   16'hACE1
`define ADFE_REC_RST     8'hFF
`define ADFE_MEM_AW      8
`define ADFE_SW          16
`define ADFE_SW_CNT      4'hF
// ---------------------------------------------------------------
// timing: frame reference 1 us, bit ref 10 MHz, supply sync clk/4
// ---------------------------------------------------------------
`define ADFE_CLK_NS      50
`define ADFE_FRAME_NS    1000
`define ADFE_FRAME_CYC   (`ADFE_FRAME_NS / `ADFE_CLK_NS)
`define ADFE_SUP_DIV     2
`define ADFE_FRAME_LAST  5'h13
`define ADFE_SUP_LAST    2'h1
`endif

// file: adfe_front_end.v
// acquisition front end: serial sample in, mixer, dither, decimation, record capture,
// source generator and tachometer time stamps, with a plain host register port.
// assumes adc data arrive msb first, one bit per clk, framed by adc_frame_ref
//
// How it works
// - serial 16-bit converter words are deserialised, then processed.
// - mux passes converter stream unless source select routes source stream.
// - trigger_seen_n pulses low when the selected trigger is seen while an armed capture waits for it.
// - one frame strobe paces sampling, source, mixer and filter; trigger edges and the tach counter act on every clk.
// - gating starts capture with pre-trigger offset or post-trigger delay.
// - mixer enable with nonzero lo_step_q mixes with oscillator into I and Q serial streams.
// - mixer disabled means scale-only, quadrature zero, no shift.
// - lfsr dither added, amplitude set by dither register.
// - narrow spans average and keep one in 2^n samples.
// - decimation zero passes every sample unchanged in rate.
// - filter accumulator lives in its own working memory.
// - output latch holds each filtered sample while written to capture memory.
// - capture stores samples after trigger; host then reads the record.
// - record_ready_n goes low once a whole record is stored.
// - read data register holds the memory sample through the answer cycle.
// - random, pink and sine made internally; other types from source memory.
// - source types, sine included, pass the decimation filter only when source select routes them.
// - acquire_sync clears the tach counter; then it counts freely.
// - each tach pulse outside an acquire_sync cycle stores the counter into tach memory for the host.
// - frame reference, bit clock and divided supply sync derived from clk.
// - host configures all units and reads or writes data over the port.
`timescale 1ns/100ps
`include "adfe_map.vh"
module adfe_front_end (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        adc_sample_stream,
    input  wire        ext_trigger,
    input  wire        tach_pulse_buffered,
    input  wire        acquire_sync,
    input  wire [7:0]  bus_addr,
    input  wire [31:0] bus_wdata,
    input  wire        bus_wr,
    input  wire        bus_rd,
    output reg  [31:0] bus_rdata,
    output reg         trigger_seen_n,
    output reg         record_ready_n,
    output reg         mixer_inphase_out,
    output reg         mixer_quadrature_out,
    output reg         source_sample_stream,
    output reg         adc_frame_ref,
    output reg         adc_bit_clock_ref,
    output reg         supply_sync_clock
);
    localparam AW = `ADFE_MEM_AW;
    localparam SW = `ADFE_SW;
    localparam [1:0] CAP_IDLE = 2'h0;
    localparam [1:0] CAP_WAIT = 2'h1;
    localparam [1:0] CAP_FILL = 2'h2;
    localparam [1:0] CAP_DONE = 2'h3;
    // ---------------------------------------------------------------
    // registers and memories
    // ---------------------------------------------------------------
    reg [7:0]    ctrl_q;
    reg [3:0]    decim_q;
    reg [7:0]    trig_q;       // pre count or post delay in samples
    reg [15:0]   lo_step_q;
    reg [3:0]    dither_q;
    reg [AW-1:0] reclen_q;
    reg [AW-1:0] src_addr_q;
    reg [AW-1:0] tach_rd_q;
    reg [SW-1:0] src_mem  [0:(1<<AW)-1];
    reg [SW-1:0] cap_mem  [0:(1<<AW)-1];
    reg [31:0]   tach_mem [0:(1<<AW)-1];
    reg [19:0]   filt_mem [0:1];   // filter working memory, one word per rail
    function hit;
        input [7:0] a;
        input [7:0] want;
        hit = (a == want);
    endfunction
    // ---------------------------------------------------------------
    // timing references
    // ---------------------------------------------------------------
    reg [4:0] frame_cnt_q;
    reg [1:0] sup_cnt_q;
    wire frame = (frame_cnt_q == 5'h00);
    // one frame strobe paces the sample, source, mixer and filter units so they cannot drift apart
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            frame_cnt_q       <= 5'h00;
            sup_cnt_q         <= 2'h0;
            adc_frame_ref     <= 1'b0;
            adc_bit_clock_ref <= 1'b0;
            supply_sync_clock <= 1'b0;
        end else begin
            frame_cnt_q       <= (frame_cnt_q == `ADFE_FRAME_LAST) ? 5'h00
                                 : frame_cnt_q + 5'h01;
            adc_frame_ref     <= frame;
            adc_bit_clock_ref <= ~adc_bit_clock_ref;
            sup_cnt_q         <= (sup_cnt_q == `ADFE_SUP_LAST) ? 2'h0 : sup_cnt_q + 2'h1;
            if (sup_cnt_q == `ADFE_SUP_LAST)
                supply_sync_clock <= ~supply_sync_clock;
        end
    end
    // ---------------------------------------------------------------
    // serial input and source path
    // ---------------------------------------------------------------
    reg [SW-1:0] shift_q, word_q;
    reg [SW-1:0] src_word_q, src_sh_q;
    reg [15:0]   lfsr_q, phase_q;
    reg [SW-1:0] pink_q;
    wire [1:0]   stype = ctrl_q[`ADFE_C_STYPE_HI:`ADFE_C_STYPE_LO];
    reg  [SW-1:0] src_next;
    // sine from a coarse triangle fold; cheap but harmonically rich
    always @* begin
        case (stype)
            `ADFE_ST_RANDOM: src_next = lfsr_q;
            `ADFE_ST_PINK:   src_next = pink_q;
            `ADFE_ST_SINE:   src_next = phase_q[15] ? ~{phase_q[14:0], 1'b0}
                                                    : {phase_q[14:0], 1'b0};
            default:         src_next = src_mem[src_addr_q];
        endcase
    end
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_q    <= 16'h0000;
            word_q     <= 16'h0000;
            src_word_q <= 16'h0000;
            src_sh_q   <= 16'h0000;
            lfsr_q     <= `ADFE_LFSR_SEED;
            phase_q    <= 16'h0000;
            pink_q     <= 16'h0000;
            source_sample_stream <= 1'b0;
        end else begin
            shift_q <= {shift_q[SW-2:0], adc_sample_stream};
            lfsr_q  <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
            if (frame) begin
                word_q     <= ctrl_q[`ADFE_C_SRCSEL] ? src_word_q : shift_q;
                src_word_q <= ctrl_q[`ADFE_C_SRCEN] ? src_next : 16'h0000;
                src_sh_q   <= ctrl_q[`ADFE_C_SRCEN] ? src_next : 16'h0000;
                phase_q    <= phase_q + lo_step_q;
                pink_q     <= pink_q - (pink_q >>> 3) + (lfsr_q >>> 3);
            end else begin
                src_sh_q <= {src_sh_q[SW-2:0], 1'b0};
            end
            source_sample_stream <= src_sh_q[SW-1];
        end
    end
    // ---------------------------------------------------------------
    // mixer, dither and decimating filter
    // ---------------------------------------------------------------
    reg  [15:0] lo_ph_q;
    wire        mix_on = ctrl_q[`ADFE_C_MIXEN];
    // square-wave oscillator: sign flips are all a one-bit mixer needs
    wire [SW-1:0] i_mix = (mix_on && lo_ph_q[15]) ? -word_q : word_q;
    wire [SW-1:0] q_mix = mix_on ? (lo_ph_q[14] ? -word_q : word_q) : 16'h0000;
    wire [SW-1:0] dith  = {{12{lfsr_q[3]}}, lfsr_q[3:0]} >>> (4'hF - dither_q);
    reg  [15:0]   dcnt_q;
    reg  [SW-1:0] filt_i_q, filt_q_q;   // output latch
    reg           filt_vld_q;
    reg  [SW-1:0] io_sh_q, qo_sh_q;
    wire [15:0]   dlast = (16'h0001 << decim_q) - 16'h0001;
    wire [19:0]   acc_i = filt_mem[0] + {{4{i_mix[SW-1]}}, i_mix + dith};
    wire [19:0]   acc_q = filt_mem[1] + {{4{q_mix[SW-1]}}, q_mix + dith};
    wire [19:0]   avg_i = $signed(acc_i) >>> decim_q;
    wire [19:0]   avg_q = $signed(acc_q) >>> decim_q;
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lo_ph_q    <= 16'h0000;
            dcnt_q     <= 16'h0000;
            filt_i_q   <= 16'h0000;
            filt_q_q   <= 16'h0000;
            filt_vld_q <= 1'b0;
            io_sh_q    <= 16'h0000;
            qo_sh_q    <= 16'h0000;
            mixer_inphase_out    <= 1'b0;
            mixer_quadrature_out <= 1'b0;
        end else begin
            filt_vld_q <= 1'b0;
            if (frame) begin
                lo_ph_q <= lo_ph_q + lo_step_q;
                io_sh_q <= i_mix;
                qo_sh_q <= q_mix;
                if (dcnt_q == dlast) begin
                    dcnt_q     <= 16'h0000;
                    filt_i_q   <= avg_i[SW-1:0];
                    filt_q_q   <= avg_q[SW-1:0];
                    filt_vld_q <= 1'b1;
                end else begin
                    dcnt_q <= dcnt_q + 16'h0001;
                end
            end else begin
                io_sh_q <= {io_sh_q[SW-2:0], 1'b0};
                qo_sh_q <= {qo_sh_q[SW-2:0], 1'b0};
            end
            mixer_inphase_out    <= io_sh_q[SW-1];
            mixer_quadrature_out <= qo_sh_q[SW-1];
        end
    end
    // working memory: cleared on each output, otherwise accumulates
    always @(posedge clk) begin
        if (frame) begin
            filt_mem[0] <= (dcnt_q == dlast) ? 20'h00000 : acc_i;
            filt_mem[1] <= (dcnt_q == dlast) ? 20'h00000 : acc_q;
        end
    end
    // ---------------------------------------------------------------
    // trigger gating and capture control
    // ---------------------------------------------------------------
    reg  [1:0]    cap_st_q;
    reg  [AW-1:0] wr_ptr_q, rd_ptr_q;
    reg  [7:0]    delay_q;
    reg           trig_d1_q;
    wire          trig_lvl  = ctrl_q[`ADFE_C_TRIGSRC] ? ext_trigger : word_q[SW-1];
    wire          trig_edge = trig_lvl & ~trig_d1_q;
    wire          arm_wr    = bus_wr & hit(bus_addr, `ADFE_A_CTRL) & bus_wdata[`ADFE_C_ARM];
    wire          fifo_rd   = bus_rd & hit(bus_addr, `ADFE_A_FIFO);
    // pre-trigger advances the pointer while waiting, but memory is written only after the trigger, from trig_q on
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cap_st_q       <= CAP_IDLE;
            wr_ptr_q       <= 8'h00;
            rd_ptr_q       <= 8'h00;
            delay_q        <= 8'h00;
            trig_d1_q      <= 1'b0;
            trigger_seen_n <= 1'b1;
            record_ready_n <= 1'b1;
        end else begin
            trig_d1_q      <= trig_lvl;
            trigger_seen_n <= 1'b1;
            if (fifo_rd) begin
                rd_ptr_q   <= rd_ptr_q + 8'h01;
                if (rd_ptr_q == reclen_q)
                    record_ready_n <= 1'b1;
            end
            case (cap_st_q)
                CAP_IDLE: begin
                    if (arm_wr) begin
                        cap_st_q       <= CAP_WAIT;
                        wr_ptr_q       <= 8'h00;
                        record_ready_n <= 1'b1;
                    end
                end
                CAP_WAIT: begin
                    if (filt_vld_q && ctrl_q[`ADFE_C_PRE])
                        wr_ptr_q <= wr_ptr_q + 8'h01;
                    if (trig_edge) begin
                        trigger_seen_n <= 1'b0;
                        cap_st_q       <= CAP_FILL;
                        delay_q        <= ctrl_q[`ADFE_C_PRE] ? 8'h00 : trig_q;
                        if (ctrl_q[`ADFE_C_PRE])
                            wr_ptr_q <= trig_q;
                    end
                end
                CAP_FILL: begin
                    if (filt_vld_q) begin
                        if (delay_q != 8'h00) begin
                            delay_q <= delay_q - 8'h01;
                        end else begin
                            wr_ptr_q <= wr_ptr_q + 8'h01;
                            if (wr_ptr_q == reclen_q) begin
                                cap_st_q       <= CAP_DONE;
                                record_ready_n <= 1'b0;
                                rd_ptr_q       <= 8'h00;
                            end
                        end
                    end
                end
                CAP_DONE: begin
                    if (record_ready_n || arm_wr)
                        cap_st_q <= arm_wr ? CAP_WAIT : CAP_IDLE;
                    if (arm_wr) begin
                        wr_ptr_q       <= 8'h00;
                        record_ready_n <= 1'b1;
                    end
                end
                default: cap_st_q <= CAP_IDLE;
            endcase
        end
    end
    always @(posedge clk) begin
        if (cap_st_q == CAP_FILL && filt_vld_q && delay_q == 8'h00)
            cap_mem[wr_ptr_q] <= filt_i_q;
    end
    // ---------------------------------------------------------------
    // tachometer
    // ---------------------------------------------------------------
    reg [31:0]   tach_cnt_q;
    reg [AW-1:0] tach_wr_q;
    reg          tach_d1_q;
    wire         tach_edge = tach_pulse_buffered & ~tach_d1_q;
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tach_cnt_q <= 32'h00000000;
            tach_wr_q  <= 8'h00;
            tach_d1_q  <= 1'b0;
        end else begin
            tach_d1_q <= tach_pulse_buffered;
            if (acquire_sync) begin
                tach_cnt_q <= 32'h00000000;
                tach_wr_q  <= 8'h00;
            end else begin
                tach_cnt_q <= tach_cnt_q + 32'h00000001;
                if (tach_edge)
                    tach_wr_q <= tach_wr_q + 8'h01;
            end
        end
    end
    always @(posedge clk) begin
        if (tach_edge && !acquire_sync)
            tach_mem[tach_wr_q] <= tach_cnt_q;
    end
    // ---------------------------------------------------------------
    // host register port
    // ---------------------------------------------------------------
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q     <= `ADFE_CTRL_RST;
            decim_q    <= `ADFE_DECIM_RST;
            trig_q     <= 8'h00;
            lo_step_q  <= 16'h0000;
            dither_q   <= 4'h0;
            reclen_q   <= `ADFE_REC_RST;
            src_addr_q <= 8'h00;
            tach_rd_q  <= 8'h00;
        end else begin
            if (bus_wr) begin
                if (hit(bus_addr, `ADFE_A_CTRL))    ctrl_q    <= bus_wdata[7:0] & 8'hFB;
                if (hit(bus_addr, `ADFE_A_DECIM))   decim_q   <= bus_wdata[3:0];
                if (hit(bus_addr, `ADFE_A_TRIG))    trig_q    <= bus_wdata[7:0];
                if (hit(bus_addr, `ADFE_A_LO_STEP)) lo_step_q <= bus_wdata[15:0];
                if (hit(bus_addr, `ADFE_A_DITHER))  dither_q  <= bus_wdata[3:0];
                if (hit(bus_addr, `ADFE_A_RECLEN))  reclen_q  <= bus_wdata[7:0];
                if (hit(bus_addr, `ADFE_A_SRCADDR)) src_addr_q <= bus_wdata[7:0];
                if (hit(bus_addr, `ADFE_A_SRCMEM))  src_addr_q <= src_addr_q + 8'h01;
                if (hit(bus_addr, `ADFE_A_TACHADDR)) tach_rd_q <= bus_wdata[7:0];
            end else if (frame && ctrl_q[`ADFE_C_SRCEN] && stype == `ADFE_ST_ARB) begin
                src_addr_q <= src_addr_q + 8'h01;        // playback walks the table
            end
        end
    end
    always @(posedge clk) begin
        if (bus_wr && hit(bus_addr, `ADFE_A_SRCMEM))
            src_mem[src_addr_q] <= bus_wdata[15:0];
    end
    // read data one cycle after the strobe; unmapped reads return zero
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_rdata <= 32'h00000000;
        end else if (bus_rd) begin
            case (bus_addr)
                `ADFE_A_CTRL:     bus_rdata <= {24'h000000, ctrl_q};
                `ADFE_A_DECIM:    bus_rdata <= {28'h0000000, decim_q};
                `ADFE_A_TRIG:     bus_rdata <= {24'h000000, trig_q};
                `ADFE_A_LO_STEP:  bus_rdata <= {16'h0000, lo_step_q};
                `ADFE_A_DITHER:   bus_rdata <= {28'h0000000, dither_q};
                `ADFE_A_STATUS:   bus_rdata <= {24'h000000, wr_ptr_q[5:0], cap_st_q} |
                                               {23'h000000, ~record_ready_n, 8'h00};
                `ADFE_A_FIFO:     bus_rdata <= {16'h0000, cap_mem[rd_ptr_q]};
                `ADFE_A_SRCADDR:  bus_rdata <= {24'h000000, src_addr_q};
                `ADFE_A_TACHADDR: bus_rdata <= {24'h000000, tach_wr_q};
                `ADFE_A_TACHDATA: bus_rdata <= tach_mem[tach_rd_q];
                `ADFE_A_RECLEN:   bus_rdata <= {24'h000000, reclen_q};
                default:          bus_rdata <= 32'h00000000;
            endcase
        end else begin
            bus_rdata <= 32'h00000000;
        end
    end
endmodule

// file: adfe_host_model.sv
// host model: register master on the plain port of the front end
// assumes one caller at a time; strobes change just after a rising edge
`timescale 1ns/100ps
`include "adfe_map.vh"
module adfe_host_model (
    input  logic        clk,
    output logic [7:0]  bus_addr,
    output logic [31:0] bus_wdata,
    output logic        bus_wr,
    output logic        bus_rd,
    input  logic [31:0] bus_rdata
);
    // idle bus from time zero
    initial begin
        bus_addr = 8'h00;
        bus_wdata = 32'h0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
    end
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= v;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, so take them there
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        @(posedge clk);
        v = bus_rdata;
    endtask
    // waveform must sit in source memory before playback is selected
    task automatic fill_src(input logic [15:0] w, input int cnt);
        wr(`ADFE_A_SRCADDR, 32'h0);
        for (int i = 0; i < cnt; i++) wr(`ADFE_A_SRCMEM, {16'h0, w ^ 16'(i)});
    endtask
endmodule

// file: adfe_front_end_checker.sv
// port assertions for the acquisition front end
// assumes it is bound to adfe_front_end; one clock, async reset active high
`timescale 1ns/100ps
`include "adfe_map.vh"
module adfe_front_end_checker (
    input logic        clk,
    input logic        sys_rst,
    input logic [7:0]  bus_addr,
    input logic        bus_wr,
    input logic        bus_rd,
    input logic [31:0] bus_rdata,
    input logic        trigger_seen_n,
    input logic        record_ready_n,
    input logic        adc_frame_ref,
    input logic        adc_bit_clock_ref,
    input logic        supply_sync_clock
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // the trigger indication opens every capture
    sequence trig_fall;
        $fell(trigger_seen_n);
    endsequence
    chk_rdata_idle: assert property (bus_rdata != 32'h0 |-> $past(bus_rd))
        else $error("read data outside the answer cycle");
    chk_unmapped_zero: assert property (bus_rd && bus_addr > `ADFE_A_RECLEN |=> bus_rdata == 32'h0)
        else $error("unmapped read not zero");
    chk_trig_pulse: assert property (trig_fall |=> trigger_seen_n)
        else $error("trigger indication longer than one cycle");
    chk_ready_wait: assert property (trig_fall |-> record_ready_n [*8])
        else $error("record ready before a record could fill");
    chk_ready_release: assert property ($rose(record_ready_n) |-> $past(bus_rd) || $past(bus_rd, 2) || $past(bus_wr) || $past(bus_wr, 2))
        else $error("record ready released without host access");
    chk_frame_period: assert property (adc_frame_ref |=> !adc_frame_ref [*8] ##12 adc_frame_ref)
        else $error("frame reference period not 20 cycles");
    chk_bit_clock: assert property (adc_bit_clock_ref |=> !adc_bit_clock_ref ##1 adc_bit_clock_ref)
        else $error("bit clock not half rate");
    chk_supply_clock: assert property ($rose(supply_sync_clock) |-> supply_sync_clock [*2] ##1 !supply_sync_clock [*2] ##1 supply_sync_clock)
        else $error("supply sync clock not quarter rate");
endmodule

// file: adfe_front_end_tb.sv
// self-checking bench for the acquisition front end with a host model
// assumes the host model and checker files are compiled before this one
`timescale 1ns/100ps
`include "adfe_map.vh"
module adfe_front_end_tb;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        adc_sample_stream = 1'b0;
    logic        ext_trigger = 1'b0;
    logic        tach_pulse_buffered = 1'b0;
    logic        acquire_sync = 1'b0;
    logic [15:0] adc_sh = 16'h0000;
    logic [31:0] bus_wdata, bus_rdata, d, v0;
    logic [7:0]  bus_addr;
    logic        bus_wr, bus_rd, trigger_seen_n, record_ready_n, mixer_inphase_out, p;
    logic        mixer_quadrature_out, source_sample_stream, adc_frame_ref;
    logic        adc_bit_clock_ref, supply_sync_clock;
    integer      seed = 32'hb11ef0a6;
    int          error_cnt = 0, comparisons = 0, n, g, t, flips;
    // 20 MHz clock
    always #25 clk = ~clk;
    // converter: a fresh random word each frame, msb first
    always @(posedge clk) begin
        adc_sh <= adc_frame_ref ? 16'($random(seed)) : {adc_sh[14:0], 1'b0};
        adc_sample_stream <= adc_sh[15];
    end
    adfe_front_end adfe_front_end_inst (.clk(clk), .sys_rst(sys_rst),
        .adc_sample_stream(adc_sample_stream), .ext_trigger(ext_trigger),
        .tach_pulse_buffered(tach_pulse_buffered), .acquire_sync(acquire_sync),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .trigger_seen_n(trigger_seen_n),
        .record_ready_n(record_ready_n), .mixer_inphase_out(mixer_inphase_out),
        .mixer_quadrature_out(mixer_quadrature_out), .adc_frame_ref(adc_frame_ref),
        .source_sample_stream(source_sample_stream), .adc_bit_clock_ref(adc_bit_clock_ref),
        .supply_sync_clock(supply_sync_clock));
    adfe_host_model adfe_host_model_inst (.clk(clk), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
    // one comparison of any value, counted
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // verdict and end of run
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // a wait that used up its bound counts as a mismatch and ends the run
    task automatic bound(input int cnt, input int lim);
        if (cnt >= lim) begin
            error_cnt++;
            $display("[ERR] wait expected %0d seen %0d", lim, cnt);
            final_report;
        end
    endtask
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        adfe_host_model_inst.rd(`ADFE_A_RECLEN, d);
        chk("reclen reset", {24'h0, `ADFE_REC_RST}, d);
        adfe_host_model_inst.rd(8'h30, d);
        chk("unmapped", 32'h0, d);
        // records at full span and at half rate; a narrow span must take longer
        for (int k = 0; k < 2; k++) begin
            adfe_host_model_inst.wr(`ADFE_A_DECIM, k);
            adfe_host_model_inst.wr(`ADFE_A_RECLEN, 32'h3);
            adfe_host_model_inst.wr(`ADFE_A_CTRL, 32'h14);
            adfe_host_model_inst.rd(`ADFE_A_CTRL, d);
            chk("arm clears", 32'h10, d);
            ext_trigger <= 1'b1;
            n = 0;
            while (trigger_seen_n !== 1'b0 && n < 20) begin
                @(posedge clk);
                n++;
            end
            bound(n, 20);
            n = 0;
            while (record_ready_n !== 1'b0 && n < 3000) begin
                @(posedge clk);
                n++;
            end
            bound(n, 3000);
            chk("record time", 1, n >= (60 << k) - 20);
            ext_trigger <= 1'b0;
            adfe_host_model_inst.rd(`ADFE_A_STATUS, d);
            chk("ready flag", 1, d[8]);
            for (int i = 0; i < 4; i++) begin
                chk("ready held", 0, record_ready_n);
                adfe_host_model_inst.rd(`ADFE_A_FIFO, d);
            end
            @(posedge clk);
            chk("ready released", 1, record_ready_n);
        end
        // tach: clear, then two pulses a random gap apart
        acquire_sync <= 1'b1;
        @(posedge clk);
        acquire_sync <= 1'b0;
        g = 5 + ($random(seed) & 15);
        t = 10 + ($random(seed) & 31);
        repeat (g) @(posedge clk);
        for (int i = 0; i < 2; i++) begin
            tach_pulse_buffered <= 1'b1;
            repeat (2) @(posedge clk);
            tach_pulse_buffered <= 1'b0;
            repeat (t - 2) @(posedge clk);
        end
        adfe_host_model_inst.wr(`ADFE_A_TACHADDR, 32'h0);
        adfe_host_model_inst.rd(`ADFE_A_TACHDATA, v0);
        adfe_host_model_inst.wr(`ADFE_A_TACHADDR, 32'h1);
        adfe_host_model_inst.rd(`ADFE_A_TACHDATA, d);
        chk("tach gap", t, d - v0);
        chk("tach start", 1, v0 + 3 >= g && v0 <= g + 3);
        // every source type, then the mixer, must move its serial output
        adfe_host_model_inst.fill_src(16'hA5A5, 256);
        adfe_host_model_inst.wr(`ADFE_A_LO_STEP, 32'h1000);
        for (int s = 0; s < 5; s++) begin
            adfe_host_model_inst.wr(`ADFE_A_CTRL, s < 4 ? 32'h8 | (s << 5) : 32'h2);
            flips = 0;
            p = 1'b0;
            repeat (300) begin
                @(posedge clk);
                flips += ((s < 4 ? source_sample_stream : mixer_quadrature_out) !== p);
                p = s < 4 ? source_sample_stream : mixer_quadrature_out;
            end
            chk("serial activity", 1, flips > 0);
        end
        adfe_host_model_inst.wr(`ADFE_A_CTRL, 32'h0);
        repeat (60) @(posedge clk);
        repeat (40) begin
            @(posedge clk);
            chk("quadrature idle", 0, mixer_quadrature_out);
        end
        final_report;
    end
endmodule
bind adfe_front_end adfe_front_end_checker adfe_front_end_checker_inst (.clk(clk),
    .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .trigger_seen_n(trigger_seen_n), .record_ready_n(record_ready_n),
    .adc_frame_ref(adc_frame_ref), .adc_bit_clock_ref(adc_bit_clock_ref),
    .supply_sync_clock(supply_sync_clock));
